// file: bench/cssp_far_end.sv
`default_nettype none
// Far-end serial device: LSB first, can also source the clock
module cssp_far_end (
  input wire logic sck,
  input wire logic so,
  output logic si,
  output logic sck_ext
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] tx_q = 8'h00;
  logic [7:0] rx_q = 8'h00;
  initial begin
    si = 1'b1;
    sck_ext = 1'b1;
  end
  // Next bit after a falling edge; a spent line shows the inverse
  always @(negedge sck) begin
    si = tx_q[0];
    tx_q = {~tx_q[0], tx_q[7:1]};
  end
  // Device output is taken on the rising edge
  always @(posedge sck) rx_q = {so, rx_q[7:1]};
  // Our own clock, unrelated in phase, still between frames
  // Offset by 1 ns so no edge ever meets a clock edge of the block
  task pulses(input int n);
    #1;
    repeat (n) begin
      sck_ext = 1'b0;
      #8 sck_ext = 1'b1;
      #8;
    end
  endtask : pulses
endmodule : cssp_far_end
`default_nettype wire

// file: bench/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cssp_pkg::*;
  logic core_clk, rst_n, cyc, stb, we, ack, sck_o, sck_oe_n;
  logic si, so, flag, sck_ext, sck_pin;
  logic [3:0] adr, sel;
  logic [31:0] wdat, rdat, q;
  logic [7:0] b, r;
  int n_errors = 0, n_tests = 0, seed = 87, n_fall = 0, n_cyc = 0;
  realtime last_t = 0, per = 0;
  // Clock pin resolves to whoever drives it
  assign sck_pin = (sck_oe_n === 1'b0) ? sck_o : sck_ext;
  cssp_shift_port i_cssp_shift_port (.core_clk(core_clk), .rst_n(rst_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .sck_i(sck_pin), .sck_o(sck_o), .sck_oe_n(sck_oe_n), .si_i(si),
    .so_o(so), .port_bit_six_i(1'b0), .serial_flag_o(flag));
  cssp_far_end i_cssp_far_end (.sck(sck_pin), .so(so), .si(si),
    .sck_ext(sck_ext));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Classic single cycle; held until ack is sampled high
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge core_clk);
      t++;
    end while (ack !== 1'b1 && t < 20);
    if (t >= 20) chk(0, 1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task setup(input logic [2:0] code, input logic [1:0] pm);
    wb(1'b1, CSSP_PMODE_OFS, {30'h0, pm});
    wb(1'b1, CSSP_MODE_OFS, {28'h0, 1'b1, code});
    repeat (CSSP_MODE_DELAY) @(posedge core_clk);
    wb(1'b1, CSSP_DATA_OFS, {24'h0, b});
    wb(1'b1, CSSP_CTRL_OFS, 32'h2);
    n_fall = 0;
    wb(1'b1, CSSP_CTRL_OFS, 32'h1);
  endtask : setup
  task frame(input logic [2:0] code, input logic [1:0] pm);
    b = $random(seed);
    r = $random(seed);
    i_cssp_far_end.tx_q = r;
    setup(code, pm);
    chk(sck_oe_n, code == CSSP_SEL_EXT);
    if (code == CSSP_SEL_EXT) i_cssp_far_end.pulses(8);
    for (int t = 0; t < 9000 && flag !== 1'b1; t++) @(posedge core_clk);
    repeat (4) @(posedge core_clk);
    chk(n_fall, 8);
    // Flopped clock pin toggles at most once a cycle
    if (code == CSSP_SEL_EXT) q = 32'h10;
    else if (code == CSSP_SEL_SYSCLK) q = 32'h8;
    else q = 16 << (2 * (5 - code));
    chk(per, q);
    chk(sck_pin, 1'b1);
    wb(1'b0, CSSP_CTRL_OFS, 32'h0);
    chk(q[1], 1'b1);
    if (pm[0]) chk(i_cssp_far_end.rx_q, b);
    wb(1'b0, CSSP_DATA_OFS, 32'h0);
    if (pm[1]) chk(q[7:0], r);
  endtask : frame
  task report_and_stop();
    $display("checks %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // Hang guard, well above the slowest frame
  always @(posedge core_clk) begin
    n_cyc++;
    if (n_cyc > 40000) begin
      n_errors++;
      report_and_stop();
    end
  end
  // Pin clock: count falls and keep the last period
  always @(negedge sck_pin) begin
    n_fall++;
    per = $realtime - last_t;
    last_t = $realtime;
  end
  initial begin
    {rst_n, cyc, stb, we, adr, wdat, sel, b} = {40'h0, 4'hF, 8'h0};
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    chk({sck_o, sck_oe_n, so, flag}, 4'hE);
    for (int a = 0; a < 16; a += 2) begin
      wb(1'b0, a[3:0], 32'h0);
      chk(q, 32'h0);
    end
    sel <= 4'h0;
    wb(1'b1, CSSP_DATA_OFS, 32'hFF);
    sel <= 4'hF;
    wb(1'b1, 4'h2, 32'hFF);
    wb(1'b0, CSSP_DATA_OFS, 32'h0);
    chk(q, 32'h0);
    $display("test reset done");
    for (int c = 2; c <= 7; c++) frame(c[2:0], 2'(1 + c % 3));
    $display("test frames done");
    wb(1'b1, CSSP_CTRL_OFS, 32'h2);
    i_cssp_far_end.pulses(8);
    repeat (4) @(posedge core_clk);
    chk(flag, 1'b1);
    wb(1'b1, CSSP_CTRL_OFS, 32'h2);
    wb(1'b1, CSSP_MODE_OFS, 32'hF);
    i_cssp_far_end.pulses(8);
    chk(flag, 1'b0);
    $display("test clock error done");
    setup(CSSP_SEL_SYSCLK, CSSP_PM_CONT);
    repeat (48) @(posedge core_clk);
    chk(flag, 1'b0);
    chk(n_fall > 20, 1'b1);
    setup(3'h4, CSSP_PM_TXRX);
    repeat (40) @(posedge core_clk);
    wb(1'b1, CSSP_MODE_OFS, 32'hC);
    repeat (4) @(posedge core_clk);
    chk(flag, 1'b1);
    chk(n_fall < 8, 1'b1);
    $display("test abort done");
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire

// file: core/cssp_pkg.sv
`default_nettype none
package cssp_pkg;
  // Word-aligned register byte offsets
  localparam logic [3:0] CSSP_MODE_OFS = 4'h0;
  localparam logic [3:0] CSSP_DATA_OFS = 4'h4;
  localparam logic [3:0] CSSP_PMODE_OFS = 4'h8;
  localparam logic [3:0] CSSP_CTRL_OFS = 4'hC;
  // Mode register fields
  localparam int CSSP_CLK_SEL_LSB = 0;
  localparam int CSSP_PIN_FN_BIT = 3;
  localparam logic [3:0] CSSP_MODE_RESET = 4'h0;
  localparam logic [1:0] CSSP_PMODE_RESET = 2'h0;
  localparam logic [7:0] CSSP_DATA_RESET = 8'h00;
  // Clock select codes
  localparam logic [2:0] CSSP_SEL_SYSCLK = 3'h6;
  localparam logic [2:0] CSSP_SEL_EXT = 3'h7;
  // Port modes
  localparam logic [1:0] CSSP_PM_CONT = 2'h0;
  localparam logic [1:0] CSSP_PM_TX = 2'h1;
  localparam logic [1:0] CSSP_PM_RX = 2'h2;
  localparam logic [1:0] CSSP_PM_TXRX = 2'h3;
  // Mode change delay in cycles; pulses per frame
  localparam int CSSP_MODE_DELAY = 2;
  localparam logic [3:0] CSSP_FRAME_PULSES = 4'h8;
  localparam int CSSP_PRE_W = 12;
  // Control register bits: start (write), flag (read/write-1-clear)
  localparam int CSSP_CTRL_START = 0;
  localparam int CSSP_CTRL_FLAG = 1;
  typedef enum logic [2:0] {
    CSSP_IDLE = 3'b001,
    CSSP_WAIT = 3'b010,
    CSSP_XFER = 3'b100
  } cssp_state_e;
endpackage : cssp_pkg
`default_nettype wire

// file: core/cssp_prescaler.sv
`default_nettype none
// Free-running divider; one-cycle tick every half period of the chosen ratio
module cssp_prescaler
  import cssp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [2:0] clk_sel,
  output logic half_tick
);
  logic [CSSP_PRE_W-1:0] cnt_q;
  logic [CSSP_PRE_W-1:0] cnt_d;
  logic [CSSP_PRE_W-1:0] half_mask;

  // Half-period mask: 2048,512,128,32,8,2 system clocks
  always_comb begin
    unique case (clk_sel)
      3'h0: half_mask = 12'h7FF;
      3'h1: half_mask = 12'h1FF;
      3'h2: half_mask = 12'h07F;
      3'h3: half_mask = 12'h01F;
      3'h4: half_mask = 12'h007;
      default: half_mask = 12'h001;
    endcase
    cnt_d = cnt_q + 12'h001;
    half_tick = ((cnt_q & half_mask) == half_mask);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule : cssp_prescaler
`default_nettype wire

// file: core/cssp_shift_port.sv
// Behaviour
// - Codes 000-101 drive prescaled clock out
// - Code 110 drives system clock halved, toggling every cycle
// - Code 111 takes clock from pin
// - Port mode picks continuous, tx, rx, both
// - Idle state ignores clock edges
// - Start to wait; falling edge to transfer
// - Counter and shifter advance together
// - Continuous mode leaves wait state only on a mode write
// - Counter wrap returns wait, sets flag
// - Internal clock emits exactly eight pulses, except in continuous mode
// - Extra pulses re-enter transfer, flag again
// - Mode write clears counter, aborts transfer
// - Out LSB first falling, in rising
// - Mode top bit selects pin role
// - Mode effective two cycles later, reset zero
`default_nettype none
module cssp_shift_port
  import cssp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_n,
  input wire logic si_i,
  output logic so_o,
  input wire logic port_bit_six_i,
  output logic serial_flag_o
);
  logic [3:0] mode_wr_q, mode_wr_d; // First half of the two-cycle delay
  logic [3:0] serial_mode_control_q, serial_mode_control_d;
  logic [1:0] pmode_q, pmode_d;
  logic [7:0] data_q, data_d;
  logic [2:0] cnt_q, cnt_d;
  logic [3:0] pulses_q, pulses_d;
  logic flag_q, flag_d;
  logic sck_q, sck_d;
  logic sck_oe_n_q, sck_oe_n_d;
  logic so_q, so_d;
  logic sck_in_q;
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  cssp_state_e state_q, state_d;
  logic half_tick;
  logic bus_req, wr_mode, wr_data, wr_start, wr_pmode, wr_ctrl;
  logic int_clk, fall_ev, rise_ev, tx_en, rx_en;
  logic [2:0] clk_sel;

  cssp_prescaler u_pre (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_sel(clk_sel),
    .half_tick(half_tick)
  );

  // Bus decode; ack on the cycle after request, never two in a row
  always_comb begin
    bus_req = wb_cyc_i && wb_stb_i && !ack_q;
    wr_mode = bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == CSSP_MODE_OFS;
    wr_data = bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == CSSP_DATA_OFS;
    wr_pmode = bus_req && wb_we_i && wb_sel_i[0]
               && wb_adr_i == CSSP_PMODE_OFS;
    wr_ctrl = bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == CSSP_CTRL_OFS;
    wr_start = wr_ctrl && wb_dat_i[CSSP_CTRL_START];
    ack_d = bus_req;
    rdat_d = '0;
    if (bus_req && !wb_we_i) begin
      unique case (wb_adr_i)
        CSSP_DATA_OFS: rdat_d = {24'h000000, data_q};
        CSSP_PMODE_OFS: rdat_d = {30'h00000000, pmode_q};
        CSSP_CTRL_OFS: rdat_d = {30'h00000000, flag_q, 1'b0};
        default: rdat_d = '0; // Mode register is write-only
      endcase
    end
  end

  // Mode path: written value lands two cycles after the write
  always_comb begin
    mode_wr_d = wr_mode ? wb_dat_i[3:0] : mode_wr_q;
    serial_mode_control_d = mode_wr_q;
    pmode_d = wr_pmode ? wb_dat_i[1:0] : pmode_q;
    clk_sel = serial_mode_control_q[CSSP_CLK_SEL_LSB +: 3];
    int_clk = (clk_sel != CSSP_SEL_EXT);
    tx_en = (pmode_q == CSSP_PM_TX)
            || (pmode_q == CSSP_PM_TXRX);
    rx_en = (pmode_q == CSSP_PM_RX) || (pmode_q == CSSP_PM_TXRX);
  end

  // Shift clock edges, from the internal generator or the pin
  always_comb begin
    sck_d = sck_q;
    pulses_d = pulses_q;
    fall_ev = 1'b0;
    rise_ev = 1'b0;
    if (int_clk) begin
      if (wr_start) begin
        pulses_d = CSSP_FRAME_PULSES;
      end
      if (clk_sel == CSSP_SEL_SYSCLK || half_tick) begin
        if (!sck_q) begin
          sck_d = 1'b1;
          rise_ev = 1'b1;
        end else if (state_q == CSSP_WAIT && pmode_q == CSSP_PM_CONT) begin
          sck_d = 1'b0;
          fall_ev = 1'b1;
        end else if (pulses_q != 4'h0 && !wr_start) begin
          sck_d = 1'b0;
          fall_ev = 1'b1;
          pulses_d = pulses_q - 4'h1;
        end
      end
      if (state_q == CSSP_IDLE) begin
        sck_d = 1'b1;
        rise_ev = 1'b0;
      end
    end else begin
      sck_d = 1'b1;
      pulses_d = 4'h0;
      fall_ev = sck_in_q && !sck_i;
      rise_ev = !sck_in_q && sck_i;
    end
    sck_oe_n_d = !(serial_mode_control_q[CSSP_PIN_FN_BIT]
                   && int_clk);
  end

  // Sequencer, counter, shifter and flag
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    data_d = wr_data ? wb_dat_i[7:0] : data_q;
    so_d = so_q;
    flag_d = flag_q;
    if (wr_ctrl && wb_dat_i[CSSP_CTRL_FLAG]) begin
      flag_d = 1'b0;
    end
    unique case (state_q)
      CSSP_IDLE: begin
        if (wr_start) begin
          state_d = CSSP_WAIT;
        end
      end
      CSSP_WAIT: begin
        if (fall_ev && pmode_q != CSSP_PM_CONT) begin
          state_d = CSSP_XFER;
          if (tx_en) begin
            so_d = data_q[0];
          end
        end
      end
      CSSP_XFER: begin
        if (fall_ev && tx_en) begin
          so_d = data_q[0];
        end
        if (rise_ev) begin
          data_d = {rx_en ? si_i : data_q[0], data_q[7:1]};
          cnt_d = cnt_q + 3'h1;
          if (cnt_q == 3'h7) begin
            state_d = CSSP_WAIT;
            flag_d = 1'b1;
          end
        end
      end
      default: state_d = CSSP_IDLE;
    endcase
    if (wr_start) begin
      cnt_d = 3'h0;
      state_d = CSSP_WAIT;
      if (state_q == CSSP_XFER) begin
        flag_d = 1'b1;
      end
    end
    if (wr_mode) begin
      cnt_d = 3'h0;
      state_d = CSSP_IDLE;
      if (state_q == CSSP_XFER) begin
        flag_d = 1'b1;
      end
    end
  end

  // Registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_wr_q <= CSSP_MODE_RESET;
      serial_mode_control_q <= CSSP_MODE_RESET;
      pmode_q <= CSSP_PMODE_RESET;
      data_q <= CSSP_DATA_RESET;
      cnt_q <= 3'h0;
      pulses_q <= 4'h0;
      flag_q <= 1'b0;
      sck_q <= 1'b1;
      sck_oe_n_q <= 1'b1;
      so_q <= 1'b1;
      sck_in_q <= 1'b1;
      ack_q <= 1'b0;
      rdat_q <= '0;
      state_q <= CSSP_IDLE;
    end else begin
      mode_wr_q <= mode_wr_d;
      serial_mode_control_q <= serial_mode_control_d;
      pmode_q <= pmode_d;
      data_q <= data_d;
      cnt_q <= cnt_d;
      pulses_q <= pulses_d;
      flag_q <= flag_d;
      sck_q <= sck_d;
      sck_oe_n_q <= sck_oe_n_d;
      so_q <= so_d;
      sck_in_q <= sck_i;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      state_q <= state_d;
    end
  end

  always_comb begin
    wb_ack_o = ack_q;
    wb_dat_o = rdat_q;
    sck_o = sck_q;
    sck_oe_n = sck_oe_n_q;
    so_o = so_q;
    serial_flag_o = flag_q;
  end

  // Sequencer, counter and flag checks
  a_flag_on_wrap: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    state_q == CSSP_XFER && rise_ev && cnt_q == 3'h7 |=> flag_q)
    else $error("flag not set on counter wrap");
  a_idle_no_count: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    state_q == CSSP_IDLE && !wr_mode |=> cnt_q == $past(cnt_q))
    else $error("counter moved while idle");
  a_mode_delay: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    wr_mode |-> ##2 serial_mode_control_q == $past(wb_dat_i[3:0], 2))
    else $error("mode not applied two cycles after write");
  a_mode_abort: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    wr_mode |=> cnt_q == 3'h0 && state_q == CSSP_IDLE)
    else $error("mode write did not clear counter");
  a_cont_stays: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    state_q == CSSP_WAIT && pmode_q == CSSP_PM_CONT && !wr_mode
    |=> state_q == CSSP_WAIT)
    else $error("continuous mode left wait state");
  a_idle_sck_high: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    state_q == CSSP_IDLE ##1 state_q == CSSP_IDLE |-> sck_q)
    else $error("clock not high while idle");
  a_start_wait: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    wr_start && !wr_mode |=> state_q == CSSP_WAIT && cnt_q == 3'h0)
    else $error("start did not enter wait");
  a_wait_to_xfer: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    state_q == CSSP_WAIT && fall_ev && pmode_q != CSSP_PM_CONT
    && !wr_mode && !wr_start |=> state_q == CSSP_XFER)
    else $error("first falling edge did not start transfer");
  a_no_shift_idle: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    state_q == CSSP_IDLE && !wr_data |=> data_q == $past(data_q))
    else $error("data shifted while idle");
  a_shift_count: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    state_q == CSSP_XFER && rise_ev && !wr_mode && !wr_start
    |=> cnt_q == $past(cnt_q) + 3'h1)
    else $error("counter did not follow the shift");
  a_wrap_rewait: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    state_q == CSSP_XFER && rise_ev && cnt_q == 3'h7 && !wr_mode
    |=> state_q == CSSP_WAIT)
    else $error("counter wrap did not return to wait");
  a_abort_flag: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    wr_mode && state_q == CSSP_XFER |=> flag_q)
    else $error("aborted transfer did not set flag");

  // Pin and clock generator checks
  a_pin_role: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !serial_mode_control_q[CSSP_PIN_FN_BIT] |=> sck_oe_n)
    else $error("clock driven while pin is a port");
  a_pin_clock_out: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    serial_mode_control_q[CSSP_PIN_FN_BIT] && int_clk |=> !sck_oe_n)
    else $error("clock pin not driven in serial role");
  a_ext_no_drive: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    clk_sel == CSSP_SEL_EXT |=> sck_oe_n)
    else $error("clock pin driven with external clock");
  a_pulse_count: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    wr_start && int_clk |=> pulses_q == CSSP_FRAME_PULSES)
    else $error("pulse budget not loaded");
  a_pulses_stop: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    int_clk && sck_q && pulses_q == 4'h0 && state_q != CSSP_IDLE
    && pmode_q != CSSP_PM_CONT && !wr_start |=> sck_q)
    else $error("clock pulse after budget spent");
  a_prescale_hold: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    int_clk && clk_sel != CSSP_SEL_SYSCLK && !half_tick
    && state_q != CSSP_IDLE |=> sck_q == $past(sck_q))
    else $error("clock moved between prescaler ticks");
  a_sysclk_toggle: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    state_q == CSSP_WAIT && pmode_q == CSSP_PM_CONT
    && clk_sel == CSSP_SEL_SYSCLK |=> sck_q != $past(sck_q))
    else $error("undivided clock did not toggle");

  // Data pin checks
  a_tx_bit_out: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    state_q == CSSP_XFER && fall_ev && tx_en |=> so_q == $past(data_q[0]))
    else $error("output bit not the register's low bit");
  a_rx_bit_in: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    state_q == CSSP_XFER && rise_ev && rx_en && !wr_mode && !wr_start
    |=> data_q[7] == $past(si_i))
    else $error("input bit not captured on rising edge");
  a_rx_so_hold: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    pmode_q == CSSP_PM_RX |=> so_q == $past(so_q))
    else $error("output pin moved in receive mode");
endmodule : cssp_shift_port
`default_nettype wire
